// *** src/mts_sequencer.sv ***
// Trigger, auto-cal, constant entry and display rate sequencer
`timescale 1ns/1ps
module mts_sequencer #(
   parameter int NUM_CAL = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // AXI4-Lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // External trigger, active low edge
   input wire logic i_ext_trig_n,
   // Measurement engine
   output logic o_meas_start,
   output logic o_meas_cal,
   output logic [$clog2(NUM_CAL)-1:0] o_cal_idx,
   output logic o_meas_abort,
   input wire logic i_meas_done,
   input wire logic [31:0] i_meas_word,
   // Engine setup
   output logic o_hires,
   output logic [3:0] o_nplc,
   output logic [2:0] o_digits,
   output mts_pkg::mts_func_t o_func
);
   import mts_pkg::*;
   localparam int CW = $clog2(NUM_CAL);

   logic [7:0] awaddr_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire, wr_ok;
   logic [9:0] key;
   logic [7:0] digit_wr;
   logic digit_go;
   logic [7:0] ctrl_q;
   logic [31:0] readout_q, y_q, z_q;
   logic entry_q, fresh_q, point_q;
   logic [31:0] cal_mem_q [NUM_CAL];
   mts_trig_t mode_q;
   mts_seq_t st_q;
   logic pend_q, cal_due_q, ext_d_q;
   logic [7:0] abort_cnt_q, abort_lim;
   logic [2:0] rate_div_q;
   logic [5:0] disp_cnt_q;
   logic trig, hires_ok, autocal, rd_done, cal_done;
   logic [3:0] top;

   assign autocal = ctrl_q[CTRL_AUTOCAL];
   assign wr_fire = aw_have_q & w_have_q & ~o_bvalid;
   assign wr_ok = awaddr_q == OFS_CTRL || awaddr_q == OFS_KEY || awaddr_q == OFS_DIGIT;
   assign key = (wr_fire && awaddr_q == OFS_KEY && wstrb_q != 4'h0) ?
                (entry_q ? (wdata_q[9:0] & 10'h00c) : wdata_q[9:0]) : 10'h000;
   assign digit_go = wr_fire && awaddr_q == OFS_DIGIT && wstrb_q[0] && entry_q;
   assign digit_wr = wdata_q[7:0];
   assign top = readout_q[23:20];
   assign rd_done = i_meas_done && st_q == SQ_READ;
   assign cal_done = i_meas_done && st_q == SQ_CAL;

   // falling edge; hold presses after the first
   assign trig = (mode_q == TM_EXT && ext_d_q && !i_ext_trig_n) ||
                 (mode_q == TM_HOLD && key[KEY_HOLD]);

   // no hires in AC or lowest ranges
   assign hires_ok = ctrl_q[CTRL_HIRES] && !ctrl_q[CTRL_LOWEST] &&
                     (mts_func_t'(ctrl_q[3:2]) == FN_DC || mts_func_t'(ctrl_q[3:2]) == FN_OHM);

   always_comb begin
      case (mts_func_t'(ctrl_q[3:2]))
         FN_DC: abort_lim = o_hires ? ABORT_DC_HR : ABORT_DC;
         FN_ACF: abort_lim = ABORT_ACF;
         FN_ACN: abort_lim = ABORT_ACN;
         FN_OHM: abort_lim = o_hires ? ABORT_OHM_HR : ABORT_OHM;
         default: abort_lim = ABORT_DC;
      endcase
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         o_awready <= !aw_have_q && !o_awready;
         o_wready <= !w_have_q && !o_wready;
         if (i_awvalid && o_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end

   // Read channel, answer one cycle after address taken
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= !o_rvalid && !o_arready && !i_arvalid ? 1'b1 : (!o_rvalid && !o_arready);
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= RESP_OKAY;
            case (i_araddr)
               OFS_CTRL: o_rdata <= {24'h0, ctrl_q};
               OFS_READOUT: o_rdata <= readout_q;
               OFS_YREG: o_rdata <= y_q;
               OFS_ZREG: o_rdata <= z_q;
               // Fixed 3-bit index field keeps the abort count in the top byte
               OFS_STATUS: o_rdata <= {abort_cnt_q, 8'h00, 3'(o_cal_idx), rate_div_q, entry_q,
                                       pend_q, cal_due_q, o_hires, st_q, mode_q};
               default: begin
                  if (i_araddr >= OFS_CALMEM && i_araddr < OFS_CALMEM + 8'(4 * NUM_CAL)
                      && i_araddr[1:0] == 2'b00) begin
                     o_rdata <= cal_mem_q[CW'((i_araddr - OFS_CALMEM) >> 2)];
                  end else begin
                     o_rdata <= 32'h0;
                     o_rresp <= RESP_SLVERR;
                  end
               end
            endcase
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Control register and engine setup
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= CTRL_RESET;
         o_hires <= 1'b0;
         o_nplc <= NPLC_NORM;
         o_digits <= DIGITS_NORM;
         o_func <= FN_DC;
      end else begin
         if (wr_fire && awaddr_q == OFS_CTRL && wstrb_q[0] && !entry_q) begin
            ctrl_q <= wdata_q[7:0];
         end
         o_hires <= hires_ok;
         o_nplc <= hires_ok ? NPLC_HIRES : NPLC_NORM;
         o_digits <= hires_ok ? DIGITS_HIRES : DIGITS_NORM;
         o_func <= mts_func_t'(ctrl_q[3:2]);
      end
   end

   // Trigger mode selection
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_q <= TM_INT;
         ext_d_q <= 1'b1;
      end else begin
         ext_d_q <= i_ext_trig_n;
         if (key[KEY_INT_TRIG] || key[KEY_DEV_CLEAR]) begin
            mode_q <= TM_INT;
         end else if (key[KEY_EXT_TRIG]) begin
            mode_q <= TM_EXT;
         end else if (key[KEY_HOLD]) begin
            mode_q <= TM_HOLD;
         end
      end
   end

   // Measurement sequencer
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= SQ_IDLE;
         pend_q <= 1'b0;
         cal_due_q <= 1'b0;
         abort_cnt_q <= 8'h00;
         o_meas_start <= 1'b0;
         o_meas_cal <= 1'b0;
         o_meas_abort <= 1'b0;
         o_cal_idx <= '0;
      end else begin
         o_meas_start <= 1'b0;
         o_meas_abort <= 1'b0;
         // count kept only while auto-cal is on
         if (!autocal) begin
            abort_cnt_q <= 8'h00;
         end
         case (st_q)
            SQ_IDLE: begin
               if (mode_q == TM_INT) begin
                  pend_q <= 1'b0;
                  o_meas_start <= 1'b1;
                  o_meas_cal <= autocal && cal_due_q;
                  st_q <= (autocal && cal_due_q) ? SQ_CAL : SQ_READ;
               end else if (pend_q || trig) begin
                  pend_q <= pend_q && trig;
                  o_meas_start <= 1'b1;
                  o_meas_cal <= 1'b0;
                  st_q <= SQ_READ;
               end else if (autocal && cal_due_q) begin
                  o_meas_start <= 1'b1;
                  o_meas_cal <= 1'b1;
                  st_q <= SQ_CAL;
               end
            end
            SQ_READ: begin
               if (trig) begin
                  pend_q <= 1'b1;
               end
               if (i_meas_done) begin
                  cal_due_q <= 1'b1;
                  st_q <= SQ_IDLE;
               end
            end
            SQ_CAL: begin
               if (i_meas_done) begin
                  abort_cnt_q <= 8'h00;
                  cal_due_q <= 1'b0;
                  o_cal_idx <= (o_cal_idx == CW'(NUM_CAL - 1)) ? '0 : o_cal_idx + 1'b1;
                  pend_q <= pend_q || trig;
                  st_q <= SQ_IDLE;
               // abort cal and take a reading
               end else if (trig && autocal && abort_cnt_q < abort_lim) begin
                  abort_cnt_q <= abort_cnt_q + 8'h01;
                  o_meas_abort <= 1'b1;
                  o_meas_start <= 1'b1;
                  o_meas_cal <= 1'b0;
                  st_q <= SQ_READ;
               end else if (trig) begin
                  pend_q <= 1'b1;
               end
            end
            default: st_q <= SQ_IDLE;
         endcase
      end
   end

   // constants replaced only by fresh cal results
   always_ff @(posedge i_clk) begin
      if (cal_done) begin
         cal_mem_q[o_cal_idx] <= i_meas_word;
      end
   end

   // Display rate divider
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rate_div_q <= RATE_DIV_RESET;
         disp_cnt_q <= 6'h00;
      end else begin
         if (key[KEY_RATE_MAX]) begin
            rate_div_q <= RATE_DIV_RESET;
         end else if (key[KEY_RATE_DEC] && rate_div_q < RATE_DIV_MAX) begin
            rate_div_q <= rate_div_q + 3'h1;
         end
         if (rd_done) begin
            disp_cnt_q <= disp_cnt_q + 6'h01;
         end
      end
   end

   // Readout, entry and constant registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         readout_q <= 32'h0;
         y_q <= 32'h0;
         z_q <= 32'h0;
         entry_q <= 1'b0;
         fresh_q <= 1'b0;
         point_q <= 1'b0;
      end else begin
         // Live reading shown only when the divider lets it through
         if (rd_done && !entry_q && ((disp_cnt_q & ((6'h01 << rate_div_q) - 6'h01)) == 6'h00)) begin
            readout_q <= i_meas_word;
         end
         if (key[KEY_ENTER_Y] || key[KEY_ENTER_Z]) begin
            readout_q <= key[KEY_ENTER_Y] ? y_q : z_q;
            entry_q <= 1'b1;
            fresh_q <= 1'b1;
            point_q <= 1'b0;
         end
         if (digit_go) begin
            if (digit_wr[DIG_SIGN]) begin
               readout_q[31] <= ~readout_q[31];
            end else if (digit_wr[DIG_POINT]) begin
               point_q <= 1'b1;
               if (fresh_q) begin
                  readout_q[30:0] <= 31'h0;
                  fresh_q <= 1'b0;
               end
            end else if (digit_wr[3:0] <= 4'h9) begin
               // echo digit; magnitude kept within range
               if (fresh_q) begin
                  readout_q <= {readout_q[31], 3'h0, 24'h0, digit_wr[3:0]};
                  fresh_q <= 1'b0;
               end else if (readout_q[27:24] == 4'h0 && top <= TOP_DIGIT_MAX &&
                            (!point_q || readout_q[30:28] < FRAC_MAX)) begin
                  readout_q[27:0] <= {readout_q[23:0], digit_wr[3:0]};
                  if (point_q) begin
                     readout_q[30:28] <= readout_q[30:28] + 3'h1;
                  end
               end
            end
         end
         // store any displayed value into either register
         if (key[KEY_STORE_Y]) begin
            y_q <= readout_q;
         end
         if (key[KEY_STORE_Z]) begin
            z_q <= readout_q;
         end
         if (key[KEY_STORE_Y] || key[KEY_STORE_Z]) begin
            entry_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_read_done_int;
      // A register write in the same cycle may change mode or auto-cal
      rd_done && mode_q == TM_INT && autocal && !wr_fire;
   endsequence
   sequence s_cal_start;
      ##[1:3] (o_meas_start && o_meas_cal);
   endsequence

   chk_int_alternate: assert property (s_read_done_int |-> s_cal_start)
      else $error("Cal did not follow reading");
   chk_pend_start: assert property (st_q == SQ_IDLE && pend_q && mode_q != TM_INT
      |=> o_meas_start && !o_meas_cal && st_q == SQ_READ)
      else $error("Pending trigger not started");
   chk_abort_reads: assert property (o_meas_abort |-> o_meas_start && !o_meas_cal && st_q == SQ_READ)
      else $error("Abort without reading");
   chk_abort_limit: assert property (st_q == SQ_CAL && trig && !i_meas_done && abort_cnt_q >= abort_lim
      |=> !o_meas_abort && pend_q)
      else $error("Abort past limit");
   chk_abort_clear: assert property (cal_done |=> abort_cnt_q == 8'h00)
      else $error("Abort count not cleared");
   chk_hires_block: assert property (o_hires |-> o_nplc == NPLC_HIRES && o_digits == DIGITS_HIRES
      && o_func != FN_ACF && o_func != FN_ACN)
      else $error("Hires in forbidden setting");
   chk_rate_sat: assert property (rate_div_q == RATE_DIV_MAX && key[KEY_RATE_DEC] && !key[KEY_RATE_MAX]
      |=> rate_div_q == RATE_DIV_MAX)
      else $error("Rate divider overran");
   chk_store_copy: assert property (key[KEY_STORE_Z] |=> z_q == $past(readout_q) && !entry_q)
      else $error("Store did not copy readout");
   chk_hold_arm: assert property (mode_q == TM_EXT && key[KEY_HOLD] && st_q == SQ_IDLE && !trig
      && !pend_q && !(autocal && cal_due_q) |=> !o_meas_start)
      else $error("Hold arming measured");
endmodule : mts_sequencer

// *** src/mts_pkg.sv ***
// Shared constants and types for the meter trigger and auto-cal sequencer
package mts_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_KEY = 8'h04;
   localparam logic [7:0] OFS_DIGIT = 8'h08;
   localparam logic [7:0] OFS_READOUT = 8'h0c;
   localparam logic [7:0] OFS_YREG = 8'h10;
   localparam logic [7:0] OFS_ZREG = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_CALMEM = 8'h40;
   // Control fields
   localparam int CTRL_AUTOCAL = 0;
   localparam int CTRL_HIRES = 1;
   localparam int CTRL_FUNC_LO = 2;
   localparam int CTRL_LOWEST = 4;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   // Key write-one pulses
   localparam int KEY_ENTER_Y = 0;
   localparam int KEY_ENTER_Z = 1;
   localparam int KEY_STORE_Y = 2;
   localparam int KEY_STORE_Z = 3;
   localparam int KEY_INT_TRIG = 4;
   localparam int KEY_EXT_TRIG = 5;
   localparam int KEY_HOLD = 6;
   localparam int KEY_RATE_DEC = 7;
   localparam int KEY_RATE_MAX = 8;
   localparam int KEY_DEV_CLEAR = 9;
   // Digit register fields
   localparam int DIG_SIGN = 4;
   localparam int DIG_POINT = 5;
   // Entry limits: seven BCD digits, up to six fractional
   localparam logic [2:0] FRAC_MAX = 3'h6;
   localparam logic [3:0] TOP_DIGIT_MAX = 4'h1;
   // Integration length in line cycles and displayed digits
   localparam logic [3:0] NPLC_NORM = 4'h1;
   localparam logic [3:0] NPLC_HIRES = 4'h8;
   localparam logic [2:0] DIGITS_NORM = 3'h6;
   localparam logic [2:0] DIGITS_HIRES = 3'h7;
   // Display rate
   localparam logic [2:0] RATE_DIV_MAX = 3'h6;
   localparam logic [2:0] RATE_DIV_RESET = 3'h0;
   // Cal abort limits per function
   localparam logic [7:0] ABORT_DC = 8'd128;
   localparam logic [7:0] ABORT_DC_HR = 8'd32;
   localparam logic [7:0] ABORT_ACF = 8'd64;
   localparam logic [7:0] ABORT_ACN = 8'd8;
   localparam logic [7:0] ABORT_OHM = 8'd64;
   localparam logic [7:0] ABORT_OHM_HR = 8'd16;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {FN_DC = 2'd0, FN_ACF = 2'd1, FN_ACN = 2'd2, FN_OHM = 2'd3} mts_func_t;
   typedef enum logic [2:0] {TM_INT = 3'b001, TM_EXT = 3'b010, TM_HOLD = 3'b100} mts_trig_t;
   typedef enum logic [2:0] {SQ_IDLE = 3'b001, SQ_READ = 3'b010, SQ_CAL = 3'b100} mts_seq_t;
endpackage : mts_pkg

// *** dv/mts_engine_model.sv ***
// Measurement engine model: answers the latest start with done after a set delay, a new start restarting the count
`timescale 1ns/1ps
module mts_engine_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Sequencer side
   input wire logic i_start,
   input wire logic [2:0] i_idx,
   input wire logic [15:0] i_dly,
   output logic o_done,
   output logic [31:0] o_word
);
   logic [15:0] cnt_q;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= 16'h0;
         o_done <= 1'b0;
         o_word <= 32'h0;
      end else begin
         o_done <= 1'b0;
         // Result word is only valid with done, so keep it moving otherwise
         o_word <= ~o_word;
         if (i_start) begin
            cnt_q <= i_dly;
         end else if (cnt_q == 16'h1) begin
            cnt_q <= 16'h0;
            o_done <= 1'b1;
            o_word <= {16'hca10, 13'h0, i_idx};
         end else if (cnt_q != 16'h0) begin
            cnt_q <= cnt_q - 16'h1;
         end
      end
   end
endmodule : mts_engine_model

// *** dv/tb.sv ***
// Self-checking bench for the trigger and auto-cal sequencer
`timescale 1ns/1ps
module tb;
   import mts_pkg::*;
   logic i_clk, i_resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, ext_trig_n = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdat, rdata, word;
   logic [3:0] wstrb = 4'hf, nplc;
   logic [1:0] brsp, rrsp, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, mstart, mcal, mabort, done, hires;
   logic [2:0] idx, digits, lastidx, i0;
   mts_func_t func;
   logic [3:0] seq [8];
   int errors = 0, tests_run = 0, nstart = 0, ncal = 0, nabort = 0, cyc = 0, s0, c0, a0;

   mts_sequencer #(.NUM_CAL(8)) mts_sequencer_i (
      .i_clk(i_clk), .i_resetn(i_resetn),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_ext_trig_n(ext_trig_n), .o_meas_start(mstart), .o_meas_cal(mcal),
      .o_cal_idx(idx), .o_meas_abort(mabort), .i_meas_done(done), .i_meas_word(word),
      .o_hires(hires), .o_nplc(nplc), .o_digits(digits), .o_func(func));
   mts_engine_model mts_engine_model_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_start(mstart), .i_idx(idx),
      .i_dly(16'd40), .o_done(done), .o_word(word));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (mstart) begin
         if (nstart < 8) seq[nstart] <= mcal ? {1'b1, idx} : 4'h0;
         nstart <= nstart + 1;
         if (mcal) ncal <= ncal + 1;
         if (mcal) lastidx <= idx;
      end
      if (mabort) nabort <= nabort + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         print_verdict();
      end
   end

   task print_verdict;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask : wt
   task axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(posedge i_clk);
         if (awready && !ta) awvalid <= 1'b0;
         if (wready && !tw) wvalid <= 1'b0;
         ta = ta | awready;
         tw = tw | wready;
      end
      while (!bvalid) @(posedge i_clk);
      brsp = bresp;
      bready <= 1'b0;
   endtask : axw
   task rd(input logic [7:0] a);
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge i_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge i_clk);
      rdat = rdata;
      rrsp = rresp;
      rready <= 1'b0;
   endtask : rd
   task key(input int b);
      axw(OFS_KEY, 32'h1 << b);
   endtask : key
   task trig;
      @(posedge i_clk);
      ext_trig_n <= 1'b0;
      wt(3);
      ext_trig_n <= 1'b1;
   endtask : trig

   task t_reset;
      chk("nplc", NPLC_NORM, nplc);
      chk("digits", DIGITS_NORM, digits);
      rd(OFS_CTRL);
      chk("ctrl", CTRL_RESET, rdat);
      chk("rresp ok", RESP_OKAY, rrsp);
      rd(8'h30);
      chk("bad rresp", RESP_SLVERR, rrsp);
      chk("bad rdata", 32'h0, rdat);
      axw(8'h34, 32'hff);
      chk("bad bresp", RESP_SLVERR, brsp);
      rd(OFS_STATUS);
      chk("mode", TM_INT, rdat[2:0]);
   endtask : t_reset
   task t_alt;
      while (nstart < 5) @(posedge i_clk);
      chk("seq0", 4'h0, seq[0]);
      chk("seq1", 4'h8, seq[1]);
      chk("seq2", 4'h0, seq[2]);
      chk("seq3", 4'h9, seq[3]);
      rd(OFS_CALMEM);
      chk("cal0", 32'hca100000, rdat);
      rd(OFS_CALMEM + 8'h4);
      chk("cal1", 32'hca100001, rdat);
   endtask : t_alt
   task t_entry;
      key(KEY_ENTER_Y);
      axw(OFS_DIGIT, 32'h1);
      axw(OFS_DIGIT, 32'h2);
      // Not a digit key, must be ignored
      key(KEY_RATE_DEC);
      rd(OFS_READOUT);
      chk("echo", 32'h12, rdat);
      key(KEY_STORE_Z);
      rd(OFS_ZREG);
      chk("zreg", 32'h12, rdat);
      rd(OFS_STATUS);
      chk("rate in entry", 32'h0, rdat[12:10]);
      key(KEY_ENTER_Z);
      rd(OFS_READOUT);
      chk("shown", 32'h12, rdat);
      key(KEY_STORE_Y);
      rd(OFS_YREG);
      chk("yreg", 32'h12, rdat);
      key(KEY_ENTER_Y);
      axw(OFS_DIGIT, 32'h10);
      axw(OFS_DIGIT, 32'h1);
      for (int i = 0; i < 5; i++) axw(OFS_DIGIT, 32'h9);
      axw(OFS_DIGIT, 32'h20);
      axw(OFS_DIGIT, 32'h9);
      // Second fraction digit would pass the top of the range
      axw(OFS_DIGIT, 32'h9);
      rd(OFS_READOUT);
      chk("range", 32'h91999999, rdat);
      key(KEY_STORE_Y);
   endtask : t_entry
   task t_rate;
      for (int i = 1; i <= 7; i++) begin
         key(KEY_RATE_DEC);
         rd(OFS_STATUS);
         chk("rate div", (i > 6) ? RATE_DIV_MAX : 3'(i), rdat[12:10]);
      end
      key(KEY_RATE_MAX);
      rd(OFS_STATUS);
      chk("rate max", RATE_DIV_RESET, rdat[12:10]);
   endtask : t_rate
   task t_hires;
      for (int f = 0; f < 4; f++) begin
         axw(OFS_CTRL, 32'h2 | (f << 2));
         wt(2);
         chk("hires", (f == 0 || f == 3), hires);
         chk("func", f, func);
         chk("nplc", (f == 0 || f == 3) ? NPLC_HIRES : NPLC_NORM, nplc);
         chk("digits", (f == 0 || f == 3) ? DIGITS_HIRES : DIGITS_NORM, digits);
      end
      axw(OFS_CTRL, 32'h12);
      chk("bresp ok", RESP_OKAY, brsp);
      wt(2);
      chk("hires low rng", 1'b0, hires);
      axw(OFS_CTRL, 32'h0);
   endtask : t_hires
   task t_ext;
      key(KEY_EXT_TRIG);
      wt(100);
      s0 = nstart;
      rd(OFS_STATUS);
      chk("ext mode", TM_EXT, rdat[2:0]);
      wt(50);
      chk("no trig", s0, nstart);
      trig();
      wt(10);
      trig();
      trig();
      wt(150);
      chk("ext starts", s0 + 2, nstart);
      rd(OFS_CALMEM);
      chk("kept", 32'hca100000, rdat);
      s0 = nstart;
      key(KEY_HOLD);
      wt(100);
      chk("hold arm", s0, nstart);
      key(KEY_HOLD);
      wt(100);
      chk("hold trig", s0 + 1, nstart);
   endtask : t_ext
   task t_mode;
      key(KEY_DEV_CLEAR);
      rd(OFS_STATUS);
      chk("clr mode", TM_INT, rdat[2:0]);
      key(KEY_HOLD);
      key(KEY_INT_TRIG);
      rd(OFS_STATUS);
      chk("int mode", TM_INT, rdat[2:0]);
      s0 = nstart;
      wt(200);
      chk("int runs", 1'b1, nstart > s0 + 2);
   endtask : t_mode
   task t_abort;
      key(KEY_EXT_TRIG);
      axw(OFS_CTRL, 32'h1);
      wt(100);
      c0 = ncal;
      trig();
      while (ncal == c0) @(posedge i_clk);
      i0 = lastidx;
      a0 = nabort;
      s0 = nstart;
      wt(5);
      trig();
      wt(10);
      chk("abort", a0 + 1, nabort);
      chk("read after abort", s0 + 1, nstart);
      rd(OFS_STATUS);
      chk("abort cnt", 32'h1, rdat[31:24]);
      c0 = ncal;
      while (ncal == c0) @(posedge i_clk);
      chk("retake idx", i0, lastidx);
      wt(60);
      rd(OFS_STATUS);
      chk("cnt cleared", 32'h0, rdat[31:24]);
      // Normal AC allows the fewest aborts
      axw(OFS_CTRL, 32'h9);
      wt(100);
      a0 = nabort;
      trig();
      for (int i = 0; i < 9; i++) begin
         c0 = ncal;
         while (ncal == c0) @(posedge i_clk);
         wt(5);
         trig();
      end
      wt(100);
      chk("abort limit", a0 + 8, nabort);
   endtask : t_abort

   initial begin
      wt(10);
      i_resetn <= 1'b1;
      t_reset();
      t_alt();
      t_entry();
      t_rate();
      t_hires();
      t_ext();
      t_mode();
      t_abort();
      print_verdict();
   end
endmodule : tb
